/* File: verilog/adc_ctrl_defines.svh */
// register offsets, field positions, reset values and phase counts of the converter control
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define ADDR_STATUS_CONTROL 2'h0
`define ADDR_RESULT_HIGH 2'h1
`define ADDR_RESULT_LOW 2'h2
`define ADDR_CONV_CONFIG 2'h3

// ****************************************
// field positions
// ****************************************
`define SC_DONE_BIT 7
`define SC_IRQ_EN_BIT 6
`define SC_CONT_BIT 5
`define SC_CHAN_HI 4
`define CFG_ASYNC_BIT 0
`define CFG_LONG_BIT 1
`define CFG_TEN_BIT 2
`define CFG_EXT_BIT 3
`define CFG_USED_HI 3

// ****************************************
// values
// ****************************************
`define CHANNEL_OFF 5'h1f
`define CHANNEL_RESET 5'h1f
`define BYTE_ZERO 8'h00
`define RESULT_RESET 10'h000
`define SAMPLE_SHORT_HALVES 6'h07
`define SAMPLE_LONG_HALVES 6'h2f
`define BIT_HALVES_LAST 6'h01
`define MSB_INDEX 4'h9
`define LSB_INDEX_TEN 4'h0
`define LSB_INDEX_EIGHT 4'h2
`define HALF_STEP_TEN 11'h001
`define HALF_STEP_EIGHT 11'h004

`endif

/* File: verilog/adc_ctrl_pkg.sv */
// types shared by the converter control
package adc_ctrl_pkg;

    typedef logic [1:0] reg_addr_t;
    typedef logic [7:0] reg_byte_t;
    typedef logic [10:0] dac_half_t;

    typedef enum logic [2:0] {
        st_idle,
        st_armed,
        st_sample,
        st_convert,
        st_transfer
    } conv_state_t;

endpackage : adc_ctrl_pkg

/* File: verilog/adc_lowpower_interrupt_control.sv */
// successive approximation converter control with flags, interrupt and low-power handling
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module adc_lowpower_interrupt_control
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned CONV_HALF_CYCLES = 63
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // register port
    input wire adc_ctrl_pkg::reg_addr_t addr_in,
    input wire adc_ctrl_pkg::reg_byte_t wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output adc_ctrl_pkg::reg_byte_t rdata_out,
    // processor power state
    input wire logic stop_mode_in,
    // analog front end
    input wire logic hw_trigger_in,
    input wire logic comparator_in,
    output adc_ctrl_pkg::dac_half_t dac_code_out,
    output logic sample_out,
    output logic [4:0] channel_out,
    output logic converter_active_out,
    // interrupt request
    output logic irq_out
);
    import adc_ctrl_pkg::*;

    // ****************************************
    // functions
    // ****************************************
    // threshold in half steps of the 10-bit grid; the half step offset gives rounding
    function automatic dac_half_t dac_threshold(input logic [9:0] trial, input logic ten);
        dac_half_t offset;
        offset = ten ? `HALF_STEP_TEN : `HALF_STEP_EIGHT;
        dac_threshold = dac_half_t'({trial, 1'b0} - offset);
    endfunction : dac_threshold

    function automatic logic is_access(input logic strobe, input reg_addr_t a,
                                       input reg_addr_t target);
        is_access = strobe && (a == target);
    endfunction : is_access

    // ****************************************
    // registers and internal signals
    // ****************************************
    conv_state_t state_reg;
    logic irq_enable_reg;
    logic continuous_reg;
    logic [4:0] channel_reg;
    logic async_clock_enable_reg;
    logic long_sample_reg;
    logic ten_bit_reg;
    logic ext_mode_reg;
    logic done_flag_reg;
    logic irq_reg;
    logic read_lock_reg;
    logic [9:0] result_reg;
    logic [9:0] trial_reg;
    logic [3:0] bit_idx_reg;
    logic [5:0] phase_reg;
    logic [15:0] div_reg;
    reg_byte_t rdata_reg;
    dac_half_t dac_reg;
    logic sample_reg;
    logic active_reg;
    logic trig_meta_reg;
    logic trig_sync_reg;
    logic trig_prev_reg;
    logic cmp_meta_reg;
    logic cmp_sync_reg;

    logic sc_write;
    logic cfg_write;
    logic low_read;
    logic high_read;
    logic stop_abort;
    logic trig_rise;
    logic half_tick;
    logic transfer_ok;
    logic [5:0] sample_last;
    logic [3:0] lsb_idx;
    logic chan_on_write;

    // ****************************************
    // decode
    // ****************************************
    assign sc_write = is_access(wr_in, addr_in, `ADDR_STATUS_CONTROL);
    assign cfg_write = is_access(wr_in, addr_in, `ADDR_CONV_CONFIG);
    assign low_read = is_access(rd_in, addr_in, `ADDR_RESULT_LOW);
    assign high_read = is_access(rd_in, addr_in, `ADDR_RESULT_HIGH);
    assign chan_on_write = (wdata_in[`SC_CHAN_HI:0] != `CHANNEL_OFF);
    assign stop_abort = stop_mode_in && !async_clock_enable_reg;
    assign trig_rise = trig_sync_reg && !trig_prev_reg;
    assign sample_last = long_sample_reg ? `SAMPLE_LONG_HALVES : `SAMPLE_SHORT_HALVES;
    assign lsb_idx = ten_bit_reg ? `LSB_INDEX_TEN : `LSB_INDEX_EIGHT;
    // converter clock runs whenever converting, stop included when async is on
    assign half_tick = (div_reg == 16'h0000);
    assign transfer_ok = (state_reg == st_transfer) && !read_lock_reg;

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            trig_meta_reg <= 1'b0;
            trig_sync_reg <= 1'b0;
            trig_prev_reg <= 1'b0;
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
        end else begin
            trig_meta_reg <= hw_trigger_in;
            trig_sync_reg <= trig_meta_reg;
            trig_prev_reg <= trig_sync_reg;
            cmp_meta_reg <= comparator_in;
            cmp_sync_reg <= cmp_meta_reg;
        end
    end

    // ****************************************
    // converter clock divider
    // ****************************************
    // held at CONV_HALF_CYCLES - 1 while idle so that each phase starts on a full half period
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_reg <= 16'h0000;
        end else if (sc_write || (state_reg != st_sample && state_reg != st_convert)) begin
            div_reg <= 16'(CONV_HALF_CYCLES - 1);
        end else if (half_tick) begin
            div_reg <= 16'(CONV_HALF_CYCLES - 1);
        end else begin
            div_reg <= div_reg - 16'h0001;
        end
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= st_idle;
            phase_reg <= 6'h00;
            bit_idx_reg <= `MSB_INDEX;
            trial_reg <= `RESULT_RESET;
        end else if (stop_abort) begin
            state_reg <= st_idle;
        end else if (sc_write) begin
            phase_reg <= 6'h00;
            if (!chan_on_write) begin
                state_reg <= st_idle;
            end else if (ext_mode_reg) begin
                state_reg <= st_armed;
            end else begin
                state_reg <= st_sample;
            end
        end else if (cfg_write) begin
            state_reg <= st_idle;
        end else begin
            case (state_reg)
                st_idle: begin
                    state_reg <= st_idle;
                end
                st_armed: begin
                    if (trig_rise) begin
                        state_reg <= st_sample;
                        phase_reg <= 6'h00;
                    end
                end
                st_sample: begin
                    if (half_tick) begin
                        if (phase_reg == sample_last - 6'h01) begin
                            state_reg <= st_convert;
                            phase_reg <= 6'h00;
                            bit_idx_reg <= `MSB_INDEX;
                            trial_reg <= 10'h200;
                        end else begin
                            phase_reg <= phase_reg + 6'h01;
                        end
                    end
                end
                st_convert: begin
                    if (half_tick) begin
                        if (phase_reg == `BIT_HALVES_LAST) begin
                            phase_reg <= 6'h00;
                            // successive halving keeps codes monotonic with none missing
                            if (bit_idx_reg == lsb_idx) begin
                                trial_reg[bit_idx_reg] <= cmp_sync_reg;
                                state_reg <= st_transfer;
                            end else begin
                                trial_reg[bit_idx_reg] <= cmp_sync_reg;
                                trial_reg[bit_idx_reg - 4'h1] <= 1'b1;
                                bit_idx_reg <= bit_idx_reg - 4'h1;
                            end
                        end else begin
                            phase_reg <= phase_reg + 6'h01;
                        end
                    end
                end
                st_transfer: begin
                    phase_reg <= 6'h00;
                    if (read_lock_reg || continuous_reg) begin
                        state_reg <= st_sample;
                    end else if (ext_mode_reg) begin
                        state_reg <= st_armed;
                    end else begin
                        state_reg <= st_idle;
                    end
                end
                default: begin
                    state_reg <= st_idle;
                end
            endcase
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_enable_reg <= 1'b0;
            continuous_reg <= 1'b0;
            channel_reg <= `CHANNEL_RESET;
        end else if (sc_write) begin
            irq_enable_reg <= wdata_in[`SC_IRQ_EN_BIT];
            continuous_reg <= wdata_in[`SC_CONT_BIT];
            channel_reg <= wdata_in[`SC_CHAN_HI:0];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            async_clock_enable_reg <= 1'b0;
            long_sample_reg <= 1'b0;
            ten_bit_reg <= 1'b0;
            ext_mode_reg <= 1'b0;
        end else if (cfg_write) begin
            async_clock_enable_reg <= wdata_in[`CFG_ASYNC_BIT];
            long_sample_reg <= wdata_in[`CFG_LONG_BIT];
            ten_bit_reg <= wdata_in[`CFG_TEN_BIT];
            ext_mode_reg <= wdata_in[`CFG_EXT_BIT];
        end
    end

    // ****************************************
    // result, flag and interrupt
    // ****************************************
    // only a finished transfer touches the result; aborts leave it alone
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            result_reg <= `RESULT_RESET;
        end else if (transfer_ok) begin
            result_reg <= trial_reg;
        end
    end

    // half-read 10-bit result blocks the next transfer so high and low stay paired
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            read_lock_reg <= 1'b0;
        end else if (low_read) begin
            read_lock_reg <= 1'b0;
        end else if (high_read && ten_bit_reg) begin
            read_lock_reg <= 1'b1;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_flag_reg <= 1'b0;
        end else if (transfer_ok) begin
            done_flag_reg <= 1'b1;
        end else if (sc_write || low_read) begin
            done_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_reg <= 1'b0;
        end else if (transfer_ok && irq_enable_reg) begin
            irq_reg <= 1'b1;
        end else if (sc_write || low_read || high_read) begin
            irq_reg <= 1'b0;
        end
    end

    // ****************************************
    // read port and analog outputs
    // ****************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_reg <= `BYTE_ZERO;
        end else if (rd_in) begin
            case (addr_in)
                `ADDR_STATUS_CONTROL: begin
                    rdata_reg <= {done_flag_reg, irq_enable_reg, continuous_reg, channel_reg};
                end
                `ADDR_RESULT_HIGH: begin
                    rdata_reg <= ten_bit_reg ? {6'h00, result_reg[9:8]} : `BYTE_ZERO;
                end
                `ADDR_RESULT_LOW: begin
                    rdata_reg <= ten_bit_reg ? result_reg[7:0] : result_reg[9:2];
                end
                `ADDR_CONV_CONFIG: begin
                    rdata_reg <= {4'h0, ext_mode_reg, ten_bit_reg, long_sample_reg,
                                  async_clock_enable_reg};
                end
                default: begin
                    rdata_reg <= `BYTE_ZERO;
                end
            endcase
        end else begin
            rdata_reg <= `BYTE_ZERO;
        end
    end

    // outputs lag the sequencer by one cycle; far below one converter clock
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dac_reg <= 11'h000;
            sample_reg <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            dac_reg <= (state_reg == st_convert) ? dac_threshold(trial_reg, ten_bit_reg)
                                                 : 11'h000;
            sample_reg <= (state_reg == st_sample);
            active_reg <= (state_reg == st_sample) || (state_reg == st_convert) ||
                          (state_reg == st_transfer);
        end
    end

    assign rdata_out = rdata_reg;
    assign dac_code_out = dac_reg;
    assign sample_out = sample_reg;
    assign channel_out = channel_reg;
    assign converter_active_out = active_reg;
    assign irq_out = irq_reg;

endmodule : adc_lowpower_interrupt_control

/* File: verif/analog_source_model.sv */
// analog source with sample capacitor and comparator facing the converter
`timescale 1ns/1ps

module analog_source_model (
    // clock
    input wire logic clk_in,
    // converter side
    input wire adc_ctrl_pkg::dac_half_t dac_code_in,
    input wire logic sample_in,
    input wire logic active_in,
    // level in quarter steps of the 10-bit grid
    input wire logic [11:0] level_in,
    output logic comparator_out
);
    import adc_ctrl_pkg::*;
    logic [11:0] held_reg = 12'h000;
    logic junk_reg = 1'b0;
    // capacitor keeps the last level once the switch opens
    always_ff @(posedge clk_in) begin
        if (sample_in) begin
            held_reg <= level_in;
        end
        junk_reg <= !junk_reg;
    end
    // unpowered comparator gives no stable answer
    assign comparator_out = active_in ? (held_reg >= {dac_code_in, 1'b0}) : junk_reg;
endmodule : analog_source_model

/* File: verif/adc_ctrl_assertions.sv */
// port-level assertions of the converter control
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module adc_ctrl_assertions #(
    parameter int unsigned CONV_HALF_CYCLES = 63
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // register port and power state
    input wire adc_ctrl_pkg::reg_addr_t addr_in,
    input wire adc_ctrl_pkg::reg_byte_t wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic stop_mode_in,
    // converter outputs
    input wire adc_ctrl_pkg::dac_half_t dac_code_out,
    input wire logic sample_out,
    input wire logic converter_active_out,
    input wire logic irq_out
);
    import adc_ctrl_pkg::*;
    localparam int unsigned SHORT_LEN = 7 * CONV_HALF_CYCLES;
    localparam int unsigned LONG_LEN = 47 * CONV_HALF_CYCLES;
    logic sc_wr, sc_wr_d;
    logic res_rd;
    logic async_reg, long_reg, ien_reg, cont_reg, parked_reg;
    int unsigned samp_reg;
    assign sc_wr = wr_in && addr_in == `ADDR_STATUS_CONTROL;
    assign res_rd = rd_in && (addr_in == `ADDR_RESULT_HIGH || addr_in == `ADDR_RESULT_LOW);
    // ********
    // mirror of software mode bits
    // ********
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            async_reg <= 1'b0;
            long_reg <= 1'b0;
        end else if (wr_in && addr_in == `ADDR_CONV_CONFIG) begin
            async_reg <= wdata_in[`CFG_ASYNC_BIT];
            long_reg <= wdata_in[`CFG_LONG_BIT];
        end
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ien_reg <= 1'b0;
            cont_reg <= 1'b0;
        end else if (sc_wr) begin
            ien_reg <= wdata_in[`SC_IRQ_EN_BIT];
            cont_reg <= wdata_in[`SC_CONT_BIT];
        end
    end
    // parked: stopped without async clock, only a status write frees it
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            parked_reg <= 1'b0;
        end else if (sc_wr) begin
            parked_reg <= 1'b0;
        end else if (stop_mode_in && !async_reg) begin
            parked_reg <= 1'b1;
        end
    end
    // long sample counts run past any repetition bound
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            samp_reg <= 0;
            sc_wr_d <= 1'b0;
        end else begin
            sc_wr_d <= sc_wr;
            samp_reg <= (sample_out && !sc_wr && !sc_wr_d) ? samp_reg + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    irq_cause_a: assert property ($rose(irq_out) |-> ien_reg && $past(converter_active_out))
        else $error("irq rose without enable or conversion");
    irq_hold_a: assert property (irq_out && !sc_wr && !res_rd |=> irq_out)
        else $error("irq dropped without clearing event");
    irq_wr_clear_a: assert property (irq_out && sc_wr && !converter_active_out |=> !irq_out)
        else $error("irq kept after status write");
    irq_rd_clear_a: assert property (irq_out && res_rd && !converter_active_out |=> !irq_out)
        else $error("irq kept after result read");
    stop_abort_a: assert property (stop_mode_in && !async_reg |-> ##[1:2] !converter_active_out)
        else $error("stop did not abort conversion");
    stop_park_a: assert property (parked_reg && $past(parked_reg) |-> !converter_active_out)
        else $error("converter woke without status write");
    sample_len_a: assert property ($fell(sample_out) && converter_active_out
        |-> samp_reg == (long_reg ? LONG_LEN : SHORT_LEN))
        else $error("sample window length wrong");
    idle_quiet_a: assert property (!converter_active_out |-> dac_code_out == 11'h000 && !sample_out)
        else $error("front end busy while powered down");
    single_idle_a: assert property ($rose(irq_out) && !cont_reg |=> !converter_active_out)
        else $error("single conversion did not power down");
    conv_done_c: cover property ($rose(irq_out));
    long_sample_c: cover property ($fell(sample_out) && long_reg);
    stop_async_c: cover property (stop_mode_in && async_reg && sample_out);
    parked_c: cover property (parked_reg && !stop_mode_in);
endmodule : adc_ctrl_assertions

bind adc_lowpower_interrupt_control adc_ctrl_assertions #(
    .CONV_HALF_CYCLES(CONV_HALF_CYCLES)
) chk_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .stop_mode_in(stop_mode_in), .dac_code_out(dac_code_out),
    .sample_out(sample_out), .converter_active_out(converter_active_out), .irq_out(irq_out)
);

/* File: verif/adc_lowpower_interrupt_control_test.sv */
// self-checking bench of the converter control
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module adc_lowpower_interrupt_control_test;
    import adc_ctrl_pkg::*;
    // short half period keeps short-sample conversions near a hundred cycles
    localparam int unsigned HALF = 4;
    localparam logic [11:0] LV10 [8] = '{12'h000, 12'h001, 12'h002, 12'h7fd, 12'h7fe, 12'hff9,
        12'hffa, 12'hfff};
    localparam logic [11:0] LV8 [6] = '{12'h000, 12'h007, 12'h008, 12'hfe7, 12'hfe8, 12'hfff};
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    reg_addr_t addr_in = 2'h0;
    reg_byte_t wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic stop_mode_in = 1'b0;
    logic hw_trigger_in = 1'b0;
    logic [11:0] level = 12'h000;
    logic comparator_in, sample_out, converter_active_out, irq_out;
    logic [4:0] channel_out;
    reg_byte_t rdata_out, hi, lo;
    dac_half_t dac_code_out;
    int n_errors = 0;
    int checked = 0;
    int samp_cycles;

    always #2 clk_in = ~clk_in;

    adc_lowpower_interrupt_control #(.CONV_HALF_CYCLES(HALF)) dut_u (
        .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .stop_mode_in(stop_mode_in),
        .hw_trigger_in(hw_trigger_in), .comparator_in(comparator_in),
        .dac_code_out(dac_code_out), .sample_out(sample_out), .channel_out(channel_out),
        .converter_active_out(converter_active_out), .irq_out(irq_out));
    analog_source_model src_u (.clk_in(clk_in), .dac_code_in(dac_code_out),
        .sample_in(sample_out), .active_in(converter_active_out), .level_in(level),
        .comparator_out(comparator_in));

    // ********
    // helpers
    // ********
    function automatic logic [10:0] code(input logic [11:0] q, input logic ten);
        logic [12:0] s;
        s = ten ? (({1'b0, q} + 13'h0002) >> 2) : (({1'b0, q} + 13'h0008) >> 4);
        return ten ? ((s > 13'h03ff) ? 11'h3ff : s[10:0]) : ((s > 13'h00ff) ? 11'h0ff : s[10:0]);
    endfunction : code
    task automatic check(input logic [10:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : check
    task automatic wr_reg(input reg_addr_t a, input reg_byte_t d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input reg_addr_t a, output reg_byte_t d);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask : rd_reg
    task automatic read_res;
        rd_reg(`ADDR_RESULT_HIGH, hi);
        rd_reg(`ADDR_RESULT_LOW, lo);
    endtask : read_res
    task automatic wait_conv;
        int seen;
        seen = 0;
        samp_cycles = 0;
        for (int i = 0; i < 2000 && !(seen && converter_active_out === 1'b0); i++) begin
            @(posedge clk_in);
            #1;
            seen |= (converter_active_out === 1'b1);
            samp_cycles += (sample_out === 1'b1);
        end
    endtask : wait_conv
    task automatic run_conv(input reg_byte_t sc);
        wr_reg(`ADDR_STATUS_CONTROL, sc);
        wait_conv();
    endtask : run_conv

    // ********
    // scenarios
    // ********
    task automatic t_reset;
        #1;
        check({3'h0, channel_out, converter_active_out, sample_out, irq_out}, 11'h0f8, "rst");
        read_res();
        check({hi[2:0], lo}, 11'h000, "rst result");
        rd_reg(`ADDR_STATUS_CONTROL, lo);
        check({3'h0, lo}, 11'h01f, "rst status");
        $display("test reset finished");
    endtask : t_reset
    task automatic t_codes;
        wr_reg(`ADDR_CONV_CONFIG, 8'h04);
        foreach (LV10[i]) begin
            level = LV10[i];
            run_conv(8'h41);
            check(11'(irq_out), 11'h001, "irq10");
            check(11'(converter_active_out), 11'h000, "idle10");
            check(11'(samp_cycles), 11'(7 * HALF), "short sample");
            read_res();
            check({hi[2:0], lo}, code(LV10[i], 1'b1), "code10");
            check(11'(irq_out), 11'h000, "irq after read");
        end
        wr_reg(`ADDR_CONV_CONFIG, 8'h02);
        foreach (LV8[i]) begin
            level = LV8[i];
            run_conv(8'h01);
            check(11'(irq_out), 11'h000, "irq masked");
            check(11'(samp_cycles), 11'(47 * HALF), "long sample");
            rd_reg(`ADDR_STATUS_CONTROL, hi);
            check(11'(hi[`SC_DONE_BIT]), 11'h001, "done8");
            read_res();
            check({hi[2:0], lo}, code(LV8[i], 1'b0), "code8");
        end
        $display("test codes finished");
    endtask : t_codes
    task automatic t_clear;
        wr_reg(`ADDR_CONV_CONFIG, 8'h04);
        level = 12'h800;
        run_conv(8'h41);
        check(11'(irq_out), 11'h001, "irq set");
        wr_reg(`ADDR_STATUS_CONTROL, 8'h5f);
        #1;
        check(11'(irq_out), 11'h000, "irq after write");
        repeat (10) @(posedge clk_in);
        #1;
        check(11'(converter_active_out), 11'h000, "channel off");
        $display("test clear finished");
    endtask : t_clear
    task automatic t_stop;
        level = 12'h400;
        wr_reg(`ADDR_STATUS_CONTROL, 8'h41);
        repeat (40) @(posedge clk_in);
        stop_mode_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        check(11'(converter_active_out), 11'h000, "stop abort");
        repeat (10) @(posedge clk_in);
        stop_mode_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        #1;
        check({irq_out, 9'h000, converter_active_out}, 11'h000, "stays idle");
        read_res();
        check({hi[2:0], lo}, code(12'h800, 1'b1), "old result");
        run_conv(8'h41);
        read_res();
        check({hi[2:0], lo}, code(12'h400, 1'b1), "restart");
        wr_reg(`ADDR_CONV_CONFIG, 8'h05);
        level = 12'h123;
        wr_reg(`ADDR_STATUS_CONTROL, 8'h41);
        stop_mode_in <= 1'b1;
        wait_conv();
        check(11'(irq_out), 11'h001, "irq in stop");
        read_res();
        check({hi[2:0], lo}, code(12'h123, 1'b1), "stop result");
        @(posedge clk_in);
        stop_mode_in <= 1'b0;
        $display("test stop finished");
    endtask : t_stop
    task automatic t_ext;
        wr_reg(`ADDR_CONV_CONFIG, 8'h0d);
        stop_mode_in <= 1'b1;
        level = 12'h3c0;
        wr_reg(`ADDR_STATUS_CONTROL, 8'h41);
        repeat (30) @(posedge clk_in);
        #1;
        check(11'(converter_active_out), 11'h000, "armed quiet");
        @(posedge clk_in);
        hw_trigger_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        hw_trigger_in <= 1'b0;
        wait_conv();
        check(11'(irq_out), 11'h001, "trigger irq");
        read_res();
        check({hi[2:0], lo}, code(12'h3c0, 1'b1), "trigger result");
        repeat (30) @(posedge clk_in);
        #1;
        check(11'(converter_active_out), 11'h000, "one conversion");
        @(posedge clk_in);
        stop_mode_in <= 1'b0;
        $display("test trigger finished");
    endtask : t_ext
    task automatic t_cont;
        wr_reg(`ADDR_CONV_CONFIG, 8'h04);
        level = 12'h600;
        wr_reg(`ADDR_STATUS_CONTROL, 8'h61);
        for (int i = 0; i < 600 && irq_out !== 1'b1; i++) begin
            @(posedge clk_in);
            #1;
        end
        read_res();
        check({hi[2:0], lo}, code(12'h600, 1'b1), "cont result");
        check(11'(converter_active_out), 11'h001, "cont running");
        run_conv(8'h41);
        check(11'(converter_active_out), 11'h000, "cont ended");
        $display("test continuous finished");
    endtask : t_cont

    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    initial begin
        repeat (30000) @(posedge clk_in);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_reset();
        t_codes();
        t_clear();
        t_stop();
        t_ext();
        t_cont();
        results();
    end
endmodule : adc_lowpower_interrupt_control_test
